// ### common/qstc_consts.vh
// Constants of the quarter-second time counter
// Assumes inclusion by the design file only
`ifndef QSTC_CONSTS_VH
`define QSTC_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define QSTC_OFS_CTRL 8'h00
`define QSTC_OFS_STAT 8'h04
`define QSTC_OFS_MATCH 8'h08
`define QSTC_OFS_COUNT 8'h0c
`define QSTC_OFS_IRQ_STAT 8'h10
`define QSTC_OFS_IRQ_CLR 8'h14
`define QSTC_OFS_IRQ_EN 8'h18
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define QSTC_CTRL_EN 7
`define QSTC_CTRL_CLKS_HI 6
`define QSTC_CTRL_CLKS_LO 5
`define QSTC_CTRL_RESTART 4
`define QSTC_CTRL_CLKOE 3
`define QSTC_CTRL_PS_HI 2
`define QSTC_CTRL_PS_LO 0
`define QSTC_CTRL_RESET 8'h01
// ----------------------------------------
// Status and control register fields
// ----------------------------------------
`define QSTC_STAT_QUARTER_SECOND_FLAG 7
`define QSTC_STAT_ONE_SECOND_FLAG 6
`define QSTC_STAT_MATCH_FLAG 5
`define QSTC_STAT_QUARTER_SECOND_IRQ_ENABLE 4
`define QSTC_STAT_ONE_SECOND_IRQ_ENABLE 3
`define QSTC_STAT_MATCH_IRQ_ENABLE 2
`define QSTC_STAT_MATCH_FUNCTION_ENABLE 1
`define QSTC_STAT_MATCH_WRITE_COMPLETE 0
// ----------------------------------------
// Clock source and prescaler codes
// ----------------------------------------
`define QSTC_CLKS_EXT 2'b00
`define QSTC_CLKS_LPO 2'b01
`define QSTC_CLKS_IRC 2'b10
`define QSTC_PS_LPO 3'h0
`define QSTC_PS_32K768 3'h1
`define QSTC_PS_32K 3'h2
`define QSTC_PS_38K4 3'h3
`define QSTC_PS_4M9152 3'h4
`define QSTC_PS_4M 3'h5
`define QSTC_PS_8M 3'h6
`define QSTC_PS_16M 3'h7
// ----------------------------------------
// Divide ratios: prescaler and reference edges per quarter second
// ----------------------------------------
`define QSTC_DIV_4M9152 9'd128
`define QSTC_DIV_4M 9'd125
`define QSTC_DIV_8M 9'd250
`define QSTC_DIV_16M 9'd500
`define QSTC_QDIV_LPO 250
`define QSTC_QDIV_32K768 8192
`define QSTC_QDIV_32K 8000
`define QSTC_QDIV_38K4 9600
`endif

// ### src/qstc_top.v
// Quarter-second time counter with AHB-Lite register slave
// Assumes hclk well above every reference clock; references are async pins
`timescale 1ns/100ps
`include "qstc_consts.vh"

module qstc_top #(
  parameter QDIV_32K768 = `QSTC_QDIV_32K768,
  parameter QDIV_32K = `QSTC_QDIV_32K,
  parameter QDIV_38K4 = `QSTC_QDIV_38K4,
  parameter QDIV_LPO = `QSTC_QDIV_LPO
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire ext_osc_clk,
  input wire internal_reference_clock,
  input wire low_power_oscillator,
  output reg counter_clock_output,
  output wire irq
);

  // ----------------------------------------
  // Reference synchronisers
  // ----------------------------------------
  wire [2:0] ref_in;
  reg [2:0] sync1_r;
  reg [2:0] sync2_r;
  reg [2:0] sync3_r;
  wire [2:0] ref_rise;

  assign ref_in = {low_power_oscillator, internal_reference_clock, ext_osc_clk};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= ref_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
        end
      end
      assign ref_rise[gi] = sync2_r[gi] & ~sync3_r[gi];
    end
  endgenerate

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [7:0] ctrl_r;
  reg [2:0] flags_r;
  reg [2:0] irq_en_r;
  reg match_en_r;
  reg match_wc_r;
  reg [7:0] match_r;
  reg [7:0] count_r;
  reg [8:0] pre_cnt_r;
  reg [13:0] q_cnt_r;

  wire mod_en = ctrl_r[`QSTC_CTRL_EN];
  wire [1:0] clk_sel = ctrl_r[`QSTC_CTRL_CLKS_HI:`QSTC_CTRL_CLKS_LO];
  wire [2:0] ps_sel = ctrl_r[`QSTC_CTRL_PS_HI:`QSTC_CTRL_PS_LO];

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  reg wr_pend_r;
  reg rd_pend_r;
  reg rd_wait_r;
  reg [7:0] addr_r;
  wire take = hsel & hready & htrans[1];
  wire wr_now = wr_pend_r;

  assign hreadyout = ~rd_wait_r;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take & hwrite;
      rd_wait_r <= take & ~hwrite;
      rd_pend_r <= rd_wait_r;
      if (take) begin
        addr_r <= haddr;
      end
    end
  end

  wire wr_ctrl = wr_now && (addr_r == `QSTC_OFS_CTRL);
  wire wr_stat = wr_now && (addr_r == `QSTC_OFS_STAT);
  wire wr_match = wr_now && (addr_r == `QSTC_OFS_MATCH);
  wire wr_iclr = wr_now && (addr_r == `QSTC_OFS_IRQ_CLR);
  wire wr_ien = wr_now && (addr_r == `QSTC_OFS_IRQ_EN);
  wire restart = wr_ctrl & hwdata[`QSTC_CTRL_RESTART];

  // ----------------------------------------
  // Reference selection and prescaler
  // ----------------------------------------
  reg ref_tick;
  reg [8:0] pre_div;
  reg [13:0] q_div;

  always @* begin
    ref_tick = ref_rise[0];
    case (clk_sel)
      `QSTC_CLKS_LPO: ref_tick = ref_rise[2];
      `QSTC_CLKS_IRC: ref_tick = ref_rise[1];
      default: ref_tick = ref_rise[0];
    endcase
  end

  always @* begin
    pre_div = 9'd1;
    q_div = QDIV_32K[13:0];
    case (ps_sel)
      `QSTC_PS_LPO: q_div = QDIV_LPO[13:0];
      `QSTC_PS_32K768: q_div = QDIV_32K768[13:0];
      `QSTC_PS_32K: q_div = QDIV_32K[13:0];
      `QSTC_PS_38K4: q_div = QDIV_38K4[13:0];
      `QSTC_PS_4M9152: begin
        pre_div = `QSTC_DIV_4M9152;
        q_div = QDIV_38K4[13:0];
      end
      `QSTC_PS_4M: pre_div = `QSTC_DIV_4M;
      `QSTC_PS_8M: pre_div = `QSTC_DIV_8M;
      `QSTC_PS_16M: pre_div = `QSTC_DIV_16M;
      default: pre_div = 9'd1;
    endcase
  end

  wire pre_done = ref_tick && (pre_cnt_r == pre_div - 9'd1);
  wire tod_tick = mod_en & pre_done;
  wire q_tick = tod_tick && (q_cnt_r == q_div - 14'd1);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= 9'h000;
      q_cnt_r <= 14'h0000;
      counter_clock_output <= 1'b0;
    end else begin
      if (!mod_en || restart) begin
        pre_cnt_r <= 9'h000;
        q_cnt_r <= 14'h0000;
      end else begin
        if (ref_tick) begin
          pre_cnt_r <= pre_done ? 9'h000 : pre_cnt_r + 9'd1;
        end
        if (tod_tick) begin
          q_cnt_r <= q_tick ? 14'h0000 : q_cnt_r + 14'd1;
        end
      end
      if (!ctrl_r[`QSTC_CTRL_CLKOE] || !mod_en) begin
        counter_clock_output <= 1'b0;
      end else if (tod_tick) begin
        counter_clock_output <= ~counter_clock_output;
      end
    end
  end

  // ----------------------------------------
  // Quarter-second counter and events
  // ----------------------------------------
  wire [7:0] count_inc = count_r + 8'd1;
  wire match_hit = match_en_r && q_tick && (count_inc[7:2] == match_r[7:2]);
  wire ev_qsec = q_tick;
  wire ev_sec = q_tick && (count_inc[1:0] == 2'b00);
  wire [2:0] ev = {ev_qsec, ev_sec, match_hit};
  wire [2:0] clr_stat = wr_stat ? hwdata[`QSTC_STAT_QUARTER_SECOND_FLAG:`QSTC_STAT_MATCH_FLAG] : 3'b000;
  wire [2:0] clr_irq = wr_iclr ? hwdata[2:0] : 3'b000;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= 8'h00;
    end else if (restart) begin
      count_r <= 8'h00;
    end else if (match_hit) begin
      count_r <= {6'h00, count_inc[1:0]};
    end else if (q_tick) begin
      count_r <= count_inc;
    end
  end

  // Set wins over a clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= 3'b000;
    end else begin
      flags_r <= (flags_r & ~(clr_stat | clr_irq)) | ev;
    end
  end

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `QSTC_CTRL_RESET;
      irq_en_r <= 3'b000;
      match_en_r <= 1'b0;
      match_wc_r <= 1'b0;
      match_r <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= {hwdata[7:5], 1'b0, hwdata[3:0]};
      end
      if (wr_stat) begin
        irq_en_r <= hwdata[`QSTC_STAT_QUARTER_SECOND_IRQ_ENABLE:`QSTC_STAT_MATCH_IRQ_ENABLE];
        match_en_r <= hwdata[`QSTC_STAT_MATCH_FUNCTION_ENABLE];
      end else if (wr_ien) begin
        irq_en_r <= hwdata[2:0];
      end
      if (wr_match) begin
        match_r <= hwdata[7:0];
        match_wc_r <= 1'b1;
      end
    end
  end

  assign irq = |(flags_r & irq_en_r);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [7:0] rd_val;

  always @* begin
    rd_val = 8'h00;
    case (addr_r)
      `QSTC_OFS_CTRL: rd_val = ctrl_r;
      `QSTC_OFS_STAT: rd_val = {flags_r, irq_en_r, match_en_r, match_wc_r};
      `QSTC_OFS_MATCH: rd_val = match_r;
      `QSTC_OFS_COUNT: rd_val = count_r;
      `QSTC_OFS_IRQ_STAT: rd_val = {5'h00, flags_r};
      `QSTC_OFS_IRQ_EN: rd_val = {5'h00, irq_en_r};
      default: rd_val = 8'h00;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait_r) begin
      hrdata <= {24'h00_0000, rd_val};
    end else if (rd_pend_r) begin
      hrdata <= 32'h0000_0000;
    end
  end

endmodule

// ### verif/qstc_top_assertions.sv
// Checker of the time counter bus answers, irq and clock output
// Bound to qstc_top; sees its ports only
`timescale 1ns/100ps
module qstc_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire counter_clock_output,
  input wire irq
);
  // ----------------------------------------
  // Data phase tracking
  // ----------------------------------------
  reg dv;
  reg dw;
  reg ce;
  reg [7:0] da;
  wire tk = hsel & hready & htrans[1];
  wire rd = dv & ~dw & hreadyout;
  wire wr = dv & dw & hready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv <= 1'b0;
      dw <= 1'b0;
      ce <= 1'b0;
      da <= 8'h00;
    end else if (hready) begin
      if (dv && dw && da == 8'h00)
        ce <= hwdata[7] & hwdata[3];
      dv <= tk;
      dw <= hwrite;
      da <= haddr;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_wr; tk && hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write data phase stalled");
  property p_rd; tk && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd: assert property (p_rd) else $error("read data phase not two cycles");
  property p_up; rd |-> hrdata[31:8] == 24'h0; endproperty
  a_up: assert property (p_up) else $error("read upper bits not zero");
  property p_rst; rd && da == 8'h00 |-> !hrdata[4]; endproperty
  a_rst: assert property (p_rst) else $error("restart bit read back set");
  property p_um; rd && da == 8'h1c |-> hrdata == 32'h0; endproperty
  a_um: assert property (p_um) else $error("unmapped read not zero");
  property p_hold; rd |=> hrdata == 32'h0; endproperty
  a_hold: assert property (p_hold) else $error("read data not released");
  property p_irq; wr && (da == 8'h04 && hwdata[4:2] == 3'h0 || da == 8'h18 && hwdata[2:0] == 3'h0) |=> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq high with enables clear");
  property p_co; !ce [*2] |-> !counter_clock_output; endproperty
  a_co: assert property (p_co) else $error("clock output active while off");
endmodule
bind qstc_top qstc_chk qstc_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .counter_clock_output, .irq);

// ### verif/tb_top.sv
// Testbench of the quarter-second time counter
// Drives the register bus and all three reference pins
`timescale 1ns/100ps
module tb_top;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic [31:0] r;
  wire hreadyout, hresp, counter_clock_output, irq;
  logic eo = 0, ir = 0, lp = 0, ph = 0;
  logic [1:0] src = 0;
  logic [2:0] rc = 0;
  int fail_count = 0, checks = 0, cyc = 0, n, i;
  logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c};
  logic [7:0] re[5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] sc[3] = '{8'h81, 8'ha0, 8'hc3};
  qstc_top #(.QDIV_32K768(4), .QDIV_32K(4), .QDIV_38K4(4), .QDIV_LPO(4)) qstc_top_i (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ext_osc_clk(eo), .internal_reference_clock(ir), .low_power_oscillator(lp), .counter_clock_output, .irq);
  initial forever #10 hclk = ~hclk;
  // ----------------------------------------
  // Reference pins and timeout
  // ----------------------------------------
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    rc <= rc + 1;
    if (rc[1:0] == 2'h3) ph <= ~ph;
    eo <= (src == 0) & ph;
    lp <= (src == 1) & ph;
    ir <= (src == 2) & ph;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task rdy;
    do @(negedge hclk); while (hreadyout !== 1'b1);
  endtask
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
    @(posedge hclk);
  endtask
  task wirq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(negedge hclk);
      n++;
    end
  endtask
  task final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    for (i = 0; i < 5; i++) begin
      xf(0, ra[i], 0);
      chk(r, {24'h0, re[i]});
    end
    $display("test reset values done");
    for (i = 0; i < 3; i++) begin
      src <= i[1:0];
      xf(1, 8'h04, 32'hf0);
      xf(1, 8'h00, {24'h0, sc[i] | 8'h10});
      wirq(200);
      chk(irq, 1);
      xf(0, 8'h04, 0);
      chk(r, 32'h90);
      xf(1, 8'h00, 0);
    end
    $display("test clock sources done");
    src <= 0;
    xf(1, 8'h00, 32'h89);
    n = 0;
    while (counter_clock_output !== 1'b1 && n < 100) begin
      @(negedge hclk);
      n++;
    end
    chk(counter_clock_output, 1);
    xf(1, 8'h00, 0);
    repeat (2) @(negedge hclk);
    chk(counter_clock_output, 0);
    $display("test clock output done");
    src <= 1;
    xf(1, 8'h04, 32'he0);
    xf(1, 8'h08, 32'h0b);
    xf(1, 8'h04, 32'h06);
    xf(1, 8'h00, 32'hb0);
    wirq(400);
    chk(irq, 1);
    xf(0, 8'h0c, 0);
    chk(r, 0);
    xf(0, 8'h04, 0);
    chk(r, 32'he7);
    xf(1, 8'h00, 32'h20);
    xf(1, 8'h18, 0);
    @(negedge hclk);
    chk(irq, 0);
    xf(0, 8'h10, 0);
    chk(r, 7);
    xf(1, 8'h14, 7);
    xf(0, 8'h04, 0);
    chk(r, 3);
    $display("test match and flags done");
    xf(1, 8'h08, 32'hf0);
    xf(1, 8'h04, 32'h06);
    xf(1, 8'h00, 32'hb0);
    wirq(9000);
    chk(32'((n + 16) / 32), 240);
    repeat (100) @(posedge hclk);
    xf(1, 8'h00, 32'hb0);
    xf(0, 8'h0c, 0);
    chk(r, 0);
    xf(1, 8'h04, 32'he0);
    @(negedge hclk);
    chk(irq, 0);
    $display("test long match and restart done");
    final_report();
  end
endmodule
